/* shared/rtc_pkg.sv */
package rtc_pkg;
  // Summary of operation
  // - chip select low forces write inhibit set
  // - host holds chip select high through sequence
  // - host writes 0h/4h before counter writes
  // - busy flag lasts at most 122.1 us
  // - pending carries collapse into one second
  // - slow hosts avoid the direct read method
  // - double read repeats the lowest required digit
  // - host writes 2h/6h for interrupt use
  // - synchronised read ends within one period
  // - adjust: write 3h/7h, busy at most 122.1us
  // - host selects level mode for cyclic interrupts
  // - level codes 8h-Ch give second to hour
  // - host alarm steps code from Ch per match
  // - level mode flag write 1 drives output low, 0 releases
  // - pulse mode: off, low, 1024 Hz, 1 Hz

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int SQUARE_HZ = 1024;
  localparam int HALF_TICK_CYCLES = SYS_CLK_HZ / (2 * SQUARE_HZ);
  localparam int UPDATE_TIME_X10_US = 1221;
  localparam int UPDATE_CYCLES =
    UPDATE_TIME_X10_US * (SYS_CLK_HZ / 1_000_000) / 10;
  localparam int SUB_W = 11;

  ////////////////////////////////////////////////////////////////////////////
  // device register map on the link, one nibble each
  localparam logic [3:0] DA_SEC1 = 4'h0;
  localparam logic [3:0] DA_HOUR10 = 4'h5;
  localparam logic [3:0] DA_FLAG = 4'hD;
  localparam logic [3:0] DA_CYCLE = 4'hE;
  localparam logic [3:0] DA_CTRL = 4'hF;
  localparam logic [2:0] LAST_DIGIT = 3'h5;
  // control write bits and status read bits
  localparam int CTL_ADJ = 0;
  localparam int CTL_KEEP = 1;
  localparam int CTL_FMT24 = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_INHIBIT = 3;
  localparam logic [3:0] CTL_SET_12 = 4'h0;
  localparam logic [3:0] CTL_SET_24 = 4'h4;
  localparam logic [3:0] CTL_RUN_12 = 4'h2;
  localparam logic [3:0] CTL_RUN_24 = 4'h6;
  localparam logic [3:0] CTL_ADJ_12 = 4'h3;
  localparam logic [3:0] CTL_ADJ_24 = 4'h7;
  // interrupt cycle codes
  localparam int CT3_BIT = 3;
  localparam logic [1:0] PULSE_LOW = 2'h1;
  localparam logic [1:0] PULSE_SQ = 2'h2;
  localparam logic [1:0] PULSE_2HZ = 2'h3;
  localparam logic [3:0] CYC_OFF = 4'h0;
  localparam logic [3:0] CYC_SEC = 4'h8;
  localparam logic [3:0] CYC_10S = 4'h9;
  localparam logic [3:0] CYC_MIN = 4'hA;
  localparam logic [3:0] CYC_10M = 4'hB;
  localparam logic [3:0] CYC_HOUR = 4'hC;
  localparam logic [3:0] CYC_DAY = 4'hD;
  // bcd limits
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [3:0] TENS_MAX = 4'h5;
  localparam logic [3:0] HOUR10_MAX = 4'h2;
  localparam logic [3:0] HOUR1_LAST = 4'h3;
  localparam logic [3:0] ADJ_ROUND_TENS = 4'h3;
  localparam logic [3:0] RST_CYCLE = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // host register map, byte addresses
  localparam int HADDR_W = 6;
  localparam logic [5:0] HR_CTRL = 6'h00;
  localparam logic [5:0] HR_CMD = 6'h04;
  localparam logic [5:0] HR_TIME_SET = 6'h08;
  localparam logic [5:0] HR_TIME_READ = 6'h0C;
  localparam logic [5:0] HR_STATUS = 6'h10;
  localparam logic [5:0] HR_IRQ_STATUS = 6'h14;
  localparam logic [5:0] HR_IRQ_CLEAR = 6'h18;
  localparam logic [5:0] HR_IRQ_ENABLE = 6'h1C;
  localparam logic [5:0] HR_ALARM = 6'h20;
  localparam int CTRL_FMT24 = 0;
  localparam int CTRL_AUTOREAD = 1;
  localparam int CTRL_PERIOD = 4;
  localparam logic [2:0] CMD_SERVICE = 3'h0;
  localparam logic [2:0] CMD_SET = 3'h1;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_DOUBLE = 3'h3;
  localparam logic [2:0] CMD_ADJUST = 3'h4;
  localparam logic [2:0] CMD_CYCLIC = 3'h5;
  localparam logic [2:0] CMD_ALARM = 3'h6;
  localparam logic [2:0] CMD_STOP = 3'h7;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RTC = 1;
  localparam int IRQ_ALARM = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* shared/rtc_link.sv */
`timescale 1ns/1ps
interface rtc_link;
  logic chipSelect;
  logic wrEn;
  logic rdEn;
  logic [3:0] addr;
  logic [3:0] wrData;
  logic [3:0] rdData;
  logic intOut;
  logic intOe_n;
  logic intLine;

  // open-drain line with pull-up, low only while the device drives it
  assign intLine = intOe_n ? 1'h1 : intOut;

  modport device (
    input chipSelect, wrEn, rdEn, addr, wrData,
    output rdData, intOut, intOe_n
  );
  modport host (
    output chipSelect, wrEn, rdEn, addr, wrData,
    input rdData, intLine
  );
endinterface

/* verilog/rtc_device.sv */
`timescale 1ns/1ps
module rtc_device #(
  parameter int halfTickCycles = rtc_pkg::HALF_TICK_CYCLES,
  parameter int busyCycles = rtc_pkg::UPDATE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  rtc_link.device link,
  output logic [23:0] timeNow,
  output logic updatePending
);
  import rtc_pkg::*;

  typedef struct packed {
    logic [5:0][3:0] digit;
    logic inhibit;
    logic carry;
    logic fmt24;
    logic [3:0] cycle;
    logic flag;
    logic [15:0] busyCnt;
    logic busy;
    logic [15:0] preCnt;
    logic [SUB_W-1:0] subCnt;
    logic [3:0] rdData;
    logic intOe_n;
  } dev_state_t;

  localparam dev_state_t DEV_RESET = '{
    inhibit: 1'h1, cycle: RST_CYCLE, intOe_n: 1'h1, default: '0};

  dev_state_t s;
  dev_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // bcd one-second step through seconds, minutes and a 24-hour day
  function automatic logic [5:0][3:0] advance(input logic [5:0][3:0] d);
    logic [5:0][3:0] r;
    r = d;
    if (d[0] != DIGIT_MAX) begin
      r[0] = d[0] + 4'h1;
    end else begin
      r[0] = '0;
      if (d[1] != TENS_MAX) begin
        r[1] = d[1] + 4'h1;
      end else begin
        r[1] = '0;
        if (d[2] != DIGIT_MAX) begin
          r[2] = d[2] + 4'h1;
        end else begin
          r[2] = '0;
          if (d[3] != TENS_MAX) begin
            r[3] = d[3] + 4'h1;
          end else begin
            r[3] = '0;
            if (d[5] == HOUR10_MAX && d[4] == HOUR1_LAST) begin
              r[5:4] = '0;
            end else if (d[4] == DIGIT_MAX) begin
              r[4] = '0;
              r[5] = d[5] + 4'h1;
            end else begin
              r[4] = d[4] + 4'h1;
            end
          end
        end
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic tick;
    logic rise;
    logic evt;
    logic drive;
    logic wrOk;
    logic r10s;
    logic rMin;
    logic r10m;
    logic rHour;
    tick = 1'h0;
    rise = 1'h0;
    evt = 1'h0;
    drive = 1'h0;
    next_s = s;
    wrOk = link.chipSelect && link.wrEn;
    r10s = s.digit[0] == DIGIT_MAX;
    rMin = r10s && s.digit[1] == TENS_MAX;
    r10m = rMin && s.digit[2] == DIGIT_MAX;
    rHour = r10m && s.digit[3] == TENS_MAX;
    // prescaler: 2048 half ticks of the square wave make one second
    if (s.preCnt == 16'(halfTickCycles - 1)) begin
      next_s.preCnt = '0;
      next_s.subCnt = s.subCnt + 11'h1;
      tick = &s.subCnt;
    end else begin
      next_s.preCnt = s.preCnt + 16'h1;
    end
    // deselect always locks the counters; a control write with CTL_KEEP clear unlocks them
    if (!link.chipSelect) begin
      next_s.inhibit = 1'h1;
    end else if (wrOk && link.addr == DA_CTRL && !link.wrData[CTL_KEEP]) begin
      next_s.inhibit = 1'h0;
    end
    rise = next_s.inhibit && !s.inhibit;
    // counting runs only while locked; unlocked seconds just leave a carry
    if (tick && s.inhibit) begin
      next_s.digit = advance(s.digit);
      case (s.cycle)
        CYC_SEC: evt = 1'h1;
        CYC_10S: evt = r10s;
        CYC_MIN: evt = rMin;
        CYC_10M: evt = r10m;
        CYC_HOUR: evt = rHour;
        CYC_DAY: evt = rHour && s.digit[5] == HOUR10_MAX &&
          s.digit[4] == HOUR1_LAST;
        default: evt = 1'h0;
      endcase
    end else if (tick) begin
      next_s.carry = 1'h1;
    end
    // one or two missed seconds both come back as a single step
    if (rise) begin
      if (s.carry || tick) begin
        next_s.digit = advance(s.digit);
      end
      next_s.carry = 1'h0;
    end
    // counter digits accept writes only while unlocked
    if (wrOk && !s.inhibit && link.addr <= DA_HOUR10) begin
      next_s.digit[link.addr[2:0]] = link.wrData;
    end
    if (wrOk && link.addr == DA_CYCLE) begin
      next_s.cycle = link.wrData;
    end
    // level mode flag: written by software, set by events; set wins
    if (wrOk && link.addr == DA_FLAG && s.cycle[CT3_BIT]) begin
      next_s.flag = link.wrData[0];
    end
    if (evt) begin
      next_s.flag = 1'h1;
    end
    // round to the nearest minute, and start the update window
    next_s.busyCnt = (s.busyCnt != '0) ? s.busyCnt - 16'h1 : '0;
    if (wrOk && link.addr == DA_CTRL) begin
      next_s.fmt24 = link.wrData[CTL_FMT24];
      if (link.wrData[CTL_ADJ]) begin
        if (s.digit[1] >= ADJ_ROUND_TENS) begin
          next_s.digit = advance({s.digit[5:2], TENS_MAX, DIGIT_MAX});
        end
        next_s.digit[1:0] = '0;
        next_s.busyCnt = 16'(busyCycles);
      end
    end
    if (rise) begin
      next_s.busyCnt = 16'(busyCycles);
    end
    next_s.busy = next_s.busyCnt != '0;
    // output drive; pulse mode ignores the flag and shows the output instead
    if (next_s.cycle[CT3_BIT]) begin
      drive = next_s.flag;
    end else begin
      case (next_s.cycle[1:0])
        PULSE_LOW: drive = 1'h1;
        PULSE_SQ: drive = next_s.subCnt[0];
        PULSE_2HZ: drive = next_s.subCnt[SUB_W-1];
        default: drive = 1'h0;
      endcase
    end
    next_s.intOe_n = !drive;
    // reads answer one cycle after the strobe
    if (link.chipSelect && link.rdEn) begin
      if (link.addr <= DA_HOUR10) begin
        next_s.rdData = s.digit[link.addr[2:0]];
      end else if (link.addr == DA_FLAG) begin
        next_s.rdData = {3'h0, s.cycle[CT3_BIT] ? s.flag : !s.intOe_n};
      end else if (link.addr == DA_CYCLE) begin
        next_s.rdData = s.cycle;
      end else if (link.addr == DA_CTRL) begin
        next_s.rdData = {s.inhibit, s.fmt24, 1'h0, s.busy};
      end else begin
        next_s.rdData = '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s <= DEV_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign link.rdData = s.rdData;
  assign link.intOe_n = s.intOe_n;
  assign link.intOut = 1'h0; // open drain only ever pulls low
  assign timeNow = s.digit;
  assign updatePending = s.busy;
endmodule

/* verilog/rtc_host.sv */
`timescale 1ns/1ps
module rtc_host (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [rtc_pkg::HADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [rtc_pkg::HADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  rtc_link.host link
);
  import rtc_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_CSUP = 4'h1,
    S_CTL = 4'h2,
    S_POLL = 4'h3,
    S_POLLW = 4'h4,
    S_WR = 4'h5,
    S_RD = 4'h6,
    S_RDW = 4'h7,
    S_DBL = 4'h8,
    S_DBLW = 4'h9,
    S_CODE = 4'hA,
    S_FLAG = 4'hB,
    S_END = 4'hC
  } seq_t;

  typedef struct packed {
    seq_t st;
    logic [2:0] op;
    logic [2:0] idx;
    logic pend;
    logic cs;
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [3:0] data;
    logic [7:0] ctrl;
    logic [23:0] timeSet;
    logic [23:0] timeRd;
    logic [15:0] alarm;
    logic armed;
    logic [1:0] stage;
    logic [2:0] irqSt;
    logic [2:0] irqEn;
    logic irq;
    logic intS1;
    logic intS2;
    logic intPrev;
    logic intReady;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic awHave;
    logic wHave;
    logic [5:0] wAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } host_state_t;

  localparam host_state_t HOST_RESET = '{st: S_IDLE, intS1: 1'h1,
    intS2: 1'h1, intPrev: 1'h1, awready: 1'h1, wready: 1'h1,
    arready: 1'h1, default: '0};

  host_state_t s;
  host_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge for the writable registers
  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] v, input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[8*i +: 8] = v[8*i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [2:0] setBits;
    logic [2:0] clrBits;
    logic cmdGo;
    logic fmt;
    logic [3:0] ctlVal;
    logic [3:0] code;
    logic hourOk;
    logic m10Ok;
    logic m1Ok;
    logic [31:0] merged;
    setBits = '0;
    clrBits = '0;
    cmdGo = 1'h0;
    next_s = s;
    merged = '0;
    fmt = s.ctrl[CTRL_FMT24];
    hourOk = s.timeRd[23:16] == s.alarm[15:8];
    m10Ok = s.timeRd[15:12] == s.alarm[7:4];
    m1Ok = s.timeRd[11:8] == s.alarm[3:0];
    next_s.wr = 1'h0;
    next_s.rd = 1'h0;
    // interrupt line is a pin: two flops before anything looks at it
    next_s.intS1 = link.intLine;
    next_s.intS2 = s.intS1;
    next_s.intPrev = s.intS2;
    if (s.intPrev && !s.intS2) begin
      setBits[IRQ_RTC] = 1'h1;
    end
    if (s.intS2) begin
      next_s.intReady = 1'h1;
    end
    // control value per operation
    case (s.op)
      CMD_SET, CMD_READ: ctlVal = fmt ? CTL_SET_24 : CTL_SET_12;
      CMD_ADJUST: ctlVal = fmt ? CTL_ADJ_24 : CTL_ADJ_12;
      default: ctlVal = fmt ? CTL_RUN_24 : CTL_RUN_12;
    endcase
    // axi write: address and data taken in either order
    if (awvalid && s.awready) begin
      next_s.awHave = 1'h1;
      next_s.wAddr = awaddr;
      next_s.awready = 1'h0;
    end
    if (wvalid && s.wready) begin
      next_s.wHave = 1'h1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
      next_s.wready = 1'h0;
    end
    if (next_s.awHave && next_s.wHave && !s.bvalid) begin
      next_s.awHave = 1'h0;
      next_s.wHave = 1'h0;
      next_s.bvalid = 1'h1;
      next_s.bresp = RESP_OKAY;
      case (next_s.wAddr)
        HR_CTRL: begin
          merged = merge({24'h0, s.ctrl}, next_s.wData, next_s.wStrb);
          next_s.ctrl = merged[7:0];
        end
        HR_CMD: begin
          // commands are dropped while a sequence runs
          if (s.st == S_IDLE && next_s.wStrb[0] &&
              next_s.wData[2:0] != CMD_SERVICE) begin
            cmdGo = 1'h1;
            next_s.op = next_s.wData[2:0];
            next_s.st = S_CSUP;
            next_s.armed = next_s.wData[2:0] == CMD_ALARM;
            next_s.stage = '0;
          end
        end
        HR_TIME_SET: begin
          merged = merge({8'h0, s.timeSet}, next_s.wData, next_s.wStrb);
          next_s.timeSet = merged[23:0];
        end
        HR_IRQ_CLEAR: clrBits = next_s.wStrb[0] ? next_s.wData[2:0] : '0;
        HR_IRQ_ENABLE: begin
          merged = merge({29'h0, s.irqEn}, next_s.wData, next_s.wStrb);
          next_s.irqEn = merged[2:0];
        end
        HR_ALARM: begin
          merged = merge({16'h0, s.alarm}, next_s.wData, next_s.wStrb);
          next_s.alarm = merged[15:0];
        end
        HR_TIME_READ, HR_STATUS, HR_IRQ_STATUS: next_s.bresp = RESP_OKAY;
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'h0;
      next_s.awready = 1'h1;
      next_s.wready = 1'h1;
    end
    // axi read: data one cycle after the address is taken
    if (arvalid && s.arready) begin
      next_s.arready = 1'h0;
      next_s.rvalid = 1'h1;
      next_s.rresp = RESP_OKAY;
      case (araddr)
        HR_CTRL: next_s.rdata = {24'h0, s.ctrl};
        HR_TIME_SET: next_s.rdata = {8'h0, s.timeSet};
        HR_TIME_READ: next_s.rdata = {8'h0, s.timeRd};
        HR_STATUS: next_s.rdata = {27'h0, s.armed, s.stage, s.intS2,
          s.st != S_IDLE};
        HR_IRQ_STATUS: next_s.rdata = {29'h0, s.irqSt};
        HR_IRQ_ENABLE: next_s.rdata = {29'h0, s.irqEn};
        HR_ALARM: next_s.rdata = {16'h0, s.alarm};
        HR_CMD, HR_IRQ_CLEAR: next_s.rdata = '0;
        default: begin
          next_s.rdata = '0;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'h0;
      next_s.arready = 1'h1;
    end
    // a fresh interrupt runs a short service read, far inside one period
    if (s.st == S_IDLE && !cmdGo && !s.intS2 && s.intReady &&
        (s.armed || s.ctrl[CTRL_AUTOREAD])) begin
      next_s.intReady = 1'h0;
      next_s.op = CMD_SERVICE;
      next_s.st = S_CSUP;
    end
    // alarm compare steps the period code from hour toward minute
    next_s.stage = (s.st == S_CODE && s.op == CMD_SERVICE) ?
      (!hourOk ? 2'h0 : (s.stage == 2'h0) ? 2'h1 : !m10Ok ? 2'h1 :
      (s.stage == 2'h1) ? 2'h2 : m1Ok ? 2'h0 : 2'h2) : next_s.stage;
    if (s.op == CMD_STOP) begin
      code = CYC_OFF;
    end else if (s.armed) begin
      code = CYC_HOUR - {2'h0, next_s.stage};
    end else begin
      code = {1'h1, s.ctrl[CTRL_PERIOD +: 3]};
    end
    // link sequencer
    case (s.st)
      S_IDLE: next_s.idx = '0;
      S_CSUP: begin
        next_s.cs = 1'h1;
        // double read leaves the counters running and locked
        next_s.st = (s.op == CMD_DOUBLE) ? S_RD : S_CTL;
      end
      S_CTL: begin
        next_s.wr = 1'h1;
        next_s.addr = DA_CTRL;
        next_s.data = ctlVal;
        next_s.st = S_POLL;
      end
      S_POLL: begin
        next_s.rd = 1'h1;
        next_s.addr = DA_CTRL;
        next_s.pend = 1'h0;
        next_s.st = S_POLLW;
      end
      S_POLLW: begin
        if (!s.pend) begin
          next_s.pend = 1'h1;
        end else if (link.rdData[ST_BUSY]) begin
          next_s.st = S_POLL;
        end else if (s.op == CMD_SET) begin
          next_s.st = S_WR;
        end else if (s.op == CMD_READ || s.op == CMD_SERVICE) begin
          next_s.st = S_RD;
        end else if (s.op == CMD_ADJUST) begin
          next_s.st = S_END;
        end else begin
          next_s.st = S_CODE;
        end
      end
      S_WR: begin
        next_s.wr = 1'h1;
        next_s.addr = {1'h0, s.idx};
        next_s.data = s.timeSet[4*s.idx +: 4];
        next_s.idx = s.idx + 3'h1;
        next_s.st = (s.idx == LAST_DIGIT) ? S_END : S_WR;
      end
      S_RD: begin
        next_s.rd = 1'h1;
        next_s.addr = {1'h0, s.idx};
        next_s.pend = 1'h0;
        next_s.st = S_RDW;
      end
      S_RDW: begin
        if (!s.pend) begin
          next_s.pend = 1'h1;
        end else begin
          next_s.timeRd[4*s.idx +: 4] = link.rdData;
          next_s.idx = (s.idx == LAST_DIGIT) ? 3'h0 : s.idx + 3'h1;
          if (s.idx != LAST_DIGIT) begin
            next_s.st = S_RD;
          end else if (s.op == CMD_DOUBLE) begin
            next_s.st = S_DBL;
          end else begin
            next_s.st = (s.op == CMD_SERVICE) ? S_CODE : S_END;
          end
        end
      end
      S_DBL: begin
        next_s.rd = 1'h1;
        next_s.addr = DA_SEC1;
        next_s.pend = 1'h0;
        next_s.st = S_DBLW;
      end
      S_DBLW: begin
        if (!s.pend) begin
          next_s.pend = 1'h1;
        end else begin
          // lowest digit moved: the set may straddle a carry, read again
          next_s.st = (link.rdData == s.timeRd[3:0]) ? S_END : S_RD;
        end
      end
      S_CODE: begin
        next_s.wr = 1'h1;
        next_s.addr = DA_CYCLE;
        next_s.data = code;
        setBits[IRQ_ALARM] = s.op == CMD_SERVICE && s.armed &&
          s.stage == 2'h2 && hourOk && m10Ok && m1Ok;
        next_s.st = S_FLAG;
      end
      S_FLAG: begin
        next_s.wr = 1'h1;
        next_s.addr = DA_FLAG;
        next_s.data = '0;
        next_s.st = S_END;
      end
      S_END: begin
        next_s.cs = 1'h0;
        setBits[IRQ_DONE] = s.op != CMD_SERVICE;
        next_s.st = S_IDLE;
      end
      default: next_s.st = S_IDLE;
    endcase
    // sticky status; a set in the clearing cycle wins
    next_s.irqSt = (s.irqSt & ~clrBits) | setBits;
    next_s.irq = |(next_s.irqSt & next_s.irqEn);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s <= HOST_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign link.chipSelect = s.cs;
  assign link.wrEn = s.wr;
  assign link.rdEn = s.rd;
  assign link.addr = s.addr;
  assign link.wrData = s.data;
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign irq = s.irq;
endmodule

/* dv/rtc_props.sv */
`timescale 1ns/1ps
module rtc_props #(
  parameter int busyCycles = 8,
  parameter int secCycles = 4096
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic chipSelect,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [3:0] addr,
  input wire logic [3:0] wrData,
  input wire logic [3:0] rdData,
  input wire logic intOe_n
);
  import rtc_pkg::*;
  logic [3:0] code;
  logic [7:0] age;
  logic [15:0] gap;
  logic unlocked, armed;
  wire ctlWr = wrEn && chipSelect && addr == DA_CTRL;
  wire ctlRd = rdEn && chipSelect && addr == DA_CTRL;
  wire codeWr = wrEn && chipSelect && addr == DA_CYCLE;
  ////////////////////////////////////////
  // link shadow; age saturates so reset looks idle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      code <= RST_CYCLE;
      age <= 8'hFF;
      gap <= 16'h0;
      unlocked <= 1'h0;
      armed <= 1'h0;
    end else begin
      if (codeWr) code <= wrData;
      age <= (ctlWr && wrData[CTL_ADJ]) || $fell(chipSelect) ? 8'h0
        : age + {7'h0, age != 8'hFF};
      unlocked <= chipSelect && (unlocked || (ctlWr && !wrData[CTL_KEEP]));
      gap <= $fell(intOe_n) ? 16'h0 : gap + 16'h1;
      // first fall after a code change has no reference period
      armed <= !(codeWr && wrData != code) && (armed || $fell(intOe_n));
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  chk_wr_strobe_single: assert property
    (wrEn |=> !wrEn || addr != $past(addr)) else $error("write strobe held");
  chk_rd_strobe_single: assert property (rdEn |=> !rdEn)
    else $error("read strobe held");
  chk_access_selected: assert property
    ((wrEn || rdEn) |-> chipSelect) else $error("access deselected");
  chk_inhibit_on_deselect: assert property
    (ctlRd && !unlocked |=> rdData[ST_INHIBIT]) else $error("not inhibited");
  chk_busy_bounded: assert property
    (ctlRd && age > busyCycles + 4 |=> !rdData[ST_BUSY])
    else $error("busy too long");
  chk_flag_release: assert property
    (wrEn && chipSelect && addr == DA_FLAG && !wrData[0] && code[CT3_BIT]
    |-> ##[1:3] intOe_n) else $error("line kept low");
  chk_second_period: assert property
    ($fell(intOe_n) && armed && code == CYC_SEC
    |-> gap >= secCycles - 2 && gap <= secCycles) else $error("bad period");
  chk_off_code_quiet: assert property
    (codeWr && wrData == CYC_OFF |-> ##3 intOe_n [*8])
    else $error("line active when off");
  cover property (ctlWr && wrData[CTL_ADJ]);
  cover property ($fell(intOe_n) && armed);
  cover property ($fell(chipSelect));
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
  import rtc_pkg::*;
  logic clk_sys = 1'h0, reset_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
  logic arvalid = 1'h0, bready = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [5:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [1:0] bresp, rresp, rr;
  logic [23:0] timeNow, tset[2] = '{24'h125045, 24'h125015};
  logic [19:0] tadj[2] = '{20'h12510, 20'h12500};
  int n_mismatch = 0, checks = 0, cyc = 0;
  rtc_link link();
  // short tick and busy so a second is 4096 cycles
  rtc_host rtc_host_inst(.clk_sys(clk_sys), .reset_n(reset_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq), .link(link.host));
  rtc_device #(.halfTickCycles(2), .busyCycles(8)) rtc_device_inst(
    .clk_sys(clk_sys), .reset_n(reset_n), .link(link.device),
    .timeNow(timeNow), .updatePending());
  rtc_props #(.busyCycles(8), .secCycles(4096)) rtc_props_inst(
    .clk_sys(clk_sys), .reset_n(reset_n), .chipSelect(link.chipSelect),
    .wrEn(link.wrEn), .rdEn(link.rdEn), .addr(link.addr),
    .wrData(link.wrData), .rdData(link.rdData), .intOe_n(link.intOe_n));
  ////////////////////////////////////////
  always #12.5 clk_sys = ~clk_sys;
  // the sequence needs under 20k cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // each channel is dropped at the edge that takes it
  task automatic axw(input logic [5:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'h1;
    do @(posedge clk_sys); while (bvalid !== 1'h1);
    rr = bresp;
    bready <= 1'h0;
  endtask
  task automatic axr(input logic [5:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk_sys); while (arready !== 1'h1);
    arvalid <= 1'h0;
    rready <= 1'h1;
    do @(posedge clk_sys); while (rvalid !== 1'h1);
    rd = rdata;
    rr = rresp;
    rready <= 1'h0;
  endtask
  // issue a command, wait for its done event, then clear it
  task automatic cmd(input logic [2:0] c, input logic ie);
    axw(HR_CMD, 32'(c));
    for (int n = 0; n < 9000 && irq !== 1'h1; n++) @(posedge clk_sys);
    chk(32'(irq), 32'(ie));
    axr(HR_IRQ_STATUS);
    chk(32'(rd[IRQ_DONE]), 32'h1);
    axw(HR_IRQ_CLEAR, 32'h1);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'h1;
    axr(HR_IRQ_STATUS);
    chk(rd, 32'h0);
    axr(6'h24);
    chk(32'(rr), 32'(RESP_SLVERR));
    axw(6'h28, 32'h0);
    chk(32'(rr), 32'(RESP_SLVERR));
    axw(HR_IRQ_ENABLE, 32'h1);
    axw(HR_CTRL, 32'h3);
    // set, read back by both methods, then round both ways
    for (int k = 0; k < 2; k++) begin
      axw(HR_TIME_SET, 32'(tset[k]));
      cmd(CMD_SET, 1'h1);
      chk(32'(timeNow[23:4]), 32'(tset[k][23:4]));
      cmd(CMD_READ + 3'(k), 1'h1);
      axr(HR_TIME_READ);
      chk(32'(rd[23:4]), 32'(tset[k][23:4]));
      cmd(CMD_ADJUST, 1'h1);
      cmd(CMD_READ, 1'h1);
      axr(HR_TIME_READ);
      chk(32'(rd[23:4]), 32'(tadj[k]));
    end
    // masked done still latches its status bit
    axw(HR_IRQ_ENABLE, 32'h0);
    cmd(CMD_DOUBLE, 1'h0);
    axw(HR_IRQ_ENABLE, 32'h3);
    cmd(CMD_CYCLIC, 1'h1);
    repeat (2) begin
      axw(HR_IRQ_CLEAR, 32'h2);
      @(posedge clk_sys);
      chk(32'(irq), 32'h0);
      for (int n = 0; n < 9000 && irq !== 1'h1; n++) @(posedge clk_sys);
      axr(HR_IRQ_STATUS);
      chk(32'(rd[IRQ_RTC]), 32'h1);
    end
    // wait out the service read
    repeat (40) @(posedge clk_sys);
    axw(HR_IRQ_ENABLE, 32'h1);
    cmd(CMD_STOP, 1'h1);
    summarize();
  end
endmodule
